// >>> src/qps_pkg.sv
// package: constants and types for the quad phase instruction sequencer
package qps_pkg;
  localparam int PHASES          = 4;
  localparam int PHASE_W         = 2;
  localparam int PC_W            = 13;
  localparam int INSTR_W         = 14;
  localparam int DADDR_W         = 7;
  localparam int DATA_W          = 8;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;
  localparam logic [PHASE_W-1:0] PH_ONE   = 2'h0;
  localparam logic [PHASE_W-1:0] PH_TWO   = 2'h1;
  localparam logic [PHASE_W-1:0] PH_THREE = 2'h2;
  localparam logic [PHASE_W-1:0] PH_FOUR  = 2'h3;
  // gray-coded phase ring: one -> two -> three -> four -> one
  typedef enum logic [1:0] {
    QPS_Q_ONE   = 2'b00,
    QPS_Q_TWO   = 2'b01,
    QPS_Q_THREE = 2'b11,
    QPS_Q_FOUR  = 2'b10
  } qps_phase_t;
  // pipeline execute slot state
  typedef enum logic [1:0] {
    QPS_EX_EMPTY = 2'b00,
    QPS_EX_RUN   = 2'b01,
    QPS_EX_FLUSH = 2'b11
  } qps_exec_t;
endpackage : qps_pkg

// >>> src/qps_phase_gen.sv
// phase generator: divides the oscillator clock into four phases
`timescale 1ns/1ns
module qps_phase_gen
  import qps_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic reset_in,
  output logic      phase_one_out,
  output logic      phase_two_out,
  output logic      phase_three_out,
  output logic      phase_four_out
);
  qps_phase_t phase_ff;
  qps_phase_t nxt_phase;

  // ----------------------------------------
  // phase ring
  // ----------------------------------------
  always_comb begin
    unique case (phase_ff)
      QPS_Q_ONE:   nxt_phase = QPS_Q_TWO;
      QPS_Q_TWO:   nxt_phase = QPS_Q_THREE;
      QPS_Q_THREE: nxt_phase = QPS_Q_FOUR;
      QPS_Q_FOUR:  nxt_phase = QPS_Q_ONE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      phase_ff <= QPS_Q_ONE;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  assign phase_one_out   = (phase_ff == QPS_Q_ONE);
  assign phase_two_out   = (phase_ff == QPS_Q_TWO);
  assign phase_three_out = (phase_ff == QPS_Q_THREE);
  assign phase_four_out  = (phase_ff == QPS_Q_FOUR);
endmodule : qps_phase_gen

// >>> src/qps_sequencer.sv
// top: quad phase fetch/execute sequencer
// Function
// - divide oscillator clock by four into four non-overlapping repeating phases
// - one instruction cycle is phases one, two, three, four in order
// - program counter increments once per cycle in phase one
// - program word captured into instruction register in phase four
// - captured instruction executes in phases two to four of next cycle
// - fetch overlaps execute for one instruction per cycle
// - program-counter-changing instructions take two instruction cycles
// - operand read in phase two, result write in phase four
// - rc mode drives cycle-rate clock output at quarter oscillator rate
// - active-low master clear holds the device in reset
`timescale 1ns/1ns
module qps_sequencer
  import qps_pkg::*;
#(
  parameter int PC_WIDTH    = PC_W,
  parameter int INSTR_WIDTH = INSTR_W
) (
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire logic                   master_clear_n_in,
  input  wire logic                   rc_mode_in,
  input  wire logic [INSTR_WIDTH-1:0] prog_word_in,
  input  wire logic                   pc_load_in,
  input  wire logic [PC_WIDTH-1:0]    pc_target_in,
  output logic [PC_WIDTH-1:0]         prog_addr_out,
  output logic [INSTR_WIDTH-1:0]      instr_out,
  output logic                        exec_valid_out,
  output logic                        flush_out,
  output logic                        phase_one_out,
  output logic                        phase_two_out,
  output logic                        phase_three_out,
  output logic                        phase_four_out,
  output logic                        data_read_out,
  output logic                        data_write_out,
  output logic                        osc_out_cycle_clock_out
);
  // ----------------------------------------
  // local signals
  // ----------------------------------------
  logic                   rst;
  logic                   p1;
  logic                   p2;
  logic                   p3;
  logic                   p4;
  logic [PHASES-1:0]      cur_ph;
  logic [PHASES-1:0]      nxt_ph;
  logic [PHASES-1:0]      ph_ff;
  logic                   fetch_end;
  logic                   exec_slot;
  logic                   live;
  logic                   jump_now;
  logic [PC_WIDTH-1:0]    pc_ff;
  logic [PC_WIDTH-1:0]    nxt_pc;
  logic [INSTR_WIDTH-1:0] ir_ff;
  logic [INSTR_WIDTH-1:0] nxt_ir;
  qps_exec_t              ex_ff;
  qps_exec_t              nxt_ex;
  logic                   jump_ff;
  logic                   nxt_jump;
  logic                   valid_ff;
  logic                   nxt_valid;
  logic                   flush_ff;
  logic                   nxt_flush;
  logic                   rd_ff;
  logic                   nxt_rd;
  logic                   wr_ff;
  logic                   nxt_wr;
  logic                   ck_ff;
  logic                   nxt_ck;

  // ----------------------------------------
  // reset and phase ring
  // ----------------------------------------
  // either source holds every register in reset
  assign rst = reset_in | ~master_clear_n_in;

  qps_phase_gen u_phase (
    .clk_in          (clk_in),
    .reset_in        (rst),
    .phase_one_out   (p1),
    .phase_two_out   (p2),
    .phase_three_out (p3),
    .phase_four_out  (p4)
  );

  assign cur_ph = {p4, p3, p2, p1};

  // ----------------------------------------
  // phase outputs
  // ----------------------------------------
  // each output flop takes the phase before it, so it stands with the ring
  generate
    for (genvar i = 0; i < PHASES; i++) begin : g_ph
      assign nxt_ph[i] = cur_ph[(i + PHASES - 1) % PHASES];
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (rst) begin
      ph_ff <= {PHASES{1'b0}};
    end else begin
      ph_ff <= nxt_ph;
    end
  end

  // ----------------------------------------
  // cycle decode
  // ----------------------------------------
  // execute runs in phases two to four of a live cycle
  assign fetch_end = p4;
  assign exec_slot = p2 | p3;
  assign live      = (ex_ff == QPS_EX_RUN);
  assign jump_now  = jump_ff | (pc_load_in & live);

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  always_comb begin
    nxt_pc = pc_ff;
    if (fetch_end && jump_now) begin
      nxt_pc = pc_target_in;
    end else if (p1) begin
      nxt_pc = pc_ff + PC_WIDTH'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      pc_ff <= PC_WIDTH'(PC_RESET);
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // ----------------------------------------
  // jump request
  // ----------------------------------------
  // a request seen in phase two or three is held until phase four
  always_comb begin
    nxt_jump = jump_ff;
    if (fetch_end) begin
      nxt_jump = 1'b0;
    end else if (exec_slot && pc_load_in && live) begin
      nxt_jump = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      jump_ff <= 1'b0;
    end else begin
      jump_ff <= nxt_jump;
    end
  end

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  always_comb begin
    nxt_ir = ir_ff;
    if (fetch_end) begin
      nxt_ir = prog_word_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      ir_ff <= INSTR_WIDTH'(NOP_WORD);
    end else begin
      ir_ff <= nxt_ir;
    end
  end

  // ----------------------------------------
  // execute slot state
  // ----------------------------------------
  // a jump turns the prefetched word into an idle cycle
  always_comb begin
    nxt_ex = ex_ff;
    unique case (ex_ff)
      QPS_EX_EMPTY: begin
        if (fetch_end) begin
          nxt_ex = QPS_EX_RUN;
        end
      end
      QPS_EX_RUN: begin
        if (fetch_end && jump_now) begin
          nxt_ex = QPS_EX_FLUSH;
        end
      end
      QPS_EX_FLUSH: begin
        if (fetch_end) begin
          nxt_ex = QPS_EX_RUN;
        end
      end
      default: begin
        nxt_ex = QPS_EX_EMPTY;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      ex_ff <= QPS_EX_EMPTY;
    end else begin
      ex_ff <= nxt_ex;
    end
  end

  // ----------------------------------------
  // live instruction flag
  // ----------------------------------------
  always_comb begin
    nxt_valid = (nxt_ex == QPS_EX_RUN);
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= nxt_valid;
    end
  end

  // ----------------------------------------
  // idle cycle flag
  // ----------------------------------------
  always_comb begin
    nxt_flush = (nxt_ex == QPS_EX_FLUSH);
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      flush_ff <= 1'b0;
    end else begin
      flush_ff <= nxt_flush;
    end
  end

  // ----------------------------------------
  // operand read slot
  // ----------------------------------------
  always_comb begin
    nxt_rd = nxt_ph[1] & live;
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      rd_ff <= 1'b0;
    end else begin
      rd_ff <= nxt_rd;
    end
  end

  // ----------------------------------------
  // result write slot
  // ----------------------------------------
  always_comb begin
    nxt_wr = nxt_ph[3] & live;
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      wr_ff <= 1'b0;
    end else begin
      wr_ff <= nxt_wr;
    end
  end

  // ----------------------------------------
  // cycle rate clock output
  // ----------------------------------------
  always_comb begin
    // high in phases three and four: one period per instruction cycle
    nxt_ck = rc_mode_in & (nxt_ph[2] | nxt_ph[3]);
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      ck_ff <= 1'b0;
    end else begin
      ck_ff <= nxt_ck;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prog_addr_out           = pc_ff;
  assign instr_out               = ir_ff;
  assign exec_valid_out          = valid_ff;
  assign flush_out               = flush_ff;
  assign phase_one_out           = ph_ff[0];
  assign phase_two_out           = ph_ff[1];
  assign phase_three_out         = ph_ff[2];
  assign phase_four_out          = ph_ff[3];
  assign data_read_out           = rd_ff;
  assign data_write_out          = wr_ff;
  assign osc_out_cycle_clock_out = ck_ff;
endmodule : qps_sequencer

// >>> tb/qps_props.sv
// checker: phase, pipeline and slot timing
`timescale 1ns/1ns
module qps_props
  import qps_pkg::*;
#(
  parameter int PC_WIDTH    = PC_W,
  parameter int INSTR_WIDTH = INSTR_W
) (
  input wire logic                   clk_in,
  input wire logic                   reset_in,
  input wire logic                   master_clear_n_in,
  input wire logic                   rc_mode_in,
  input wire logic                   pc_load_in,
  input wire logic [INSTR_WIDTH-1:0] prog_word_in,
  input wire logic [INSTR_WIDTH-1:0] instr_out,
  input wire logic [PC_WIDTH-1:0]    pc_target_in,
  input wire logic [PC_WIDTH-1:0]    prog_addr_out,
  input wire logic                   exec_valid_out,
  input wire logic                   flush_out,
  input wire logic                   data_read_out,
  input wire logic                   data_write_out,
  input wire logic                   phase_one_out,
  input wire logic                   phase_two_out,
  input wire logic                   phase_three_out,
  input wire logic                   phase_four_out,
  input wire logic                   osc_out_cycle_clock_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in || !master_clear_n_in);
  wire logic [3:0] ph = {phase_four_out, phase_three_out, phase_two_out, phase_one_out};
  ph_onehot_a: assert property ($onehot0(ph)) else $error("phases overlap");
  ph_order_a: assert property (phase_one_out |=> phase_two_out ##1 phase_three_out
    ##1 phase_four_out ##1 phase_one_out) else $error("phase order broken");
  pc_step_a: assert property (phase_one_out |=>
    prog_addr_out == $past(prog_addr_out) + 1'b1) else $error("pc step wrong");
  ir_cap_a: assert property (phase_four_out |=>
    instr_out == $past(prog_word_in)) else $error("ir capture wrong");
  ir_hold_a: assert property (!phase_four_out |=> $stable(instr_out)) else $error("ir moved");
  rd_slot_a: assert property (data_read_out == (phase_two_out && exec_valid_out))
    else $error("read slot wrong");
  wr_slot_a: assert property (data_write_out == (phase_four_out && exec_valid_out))
    else $error("write slot wrong");
  pc_jump_a: assert property (phase_four_out && exec_valid_out && pc_load_in |=>
    flush_out && !exec_valid_out && prog_addr_out == $past(pc_target_in))
    else $error("jump wrong");
  flush_refill_a: assert property ($rose(flush_out) |-> ##4 (exec_valid_out && !flush_out))
    else $error("no refill");
  flush_once_a: assert property (phase_four_out && !exec_valid_out |=> !flush_out)
    else $error("idle cycle repeated");
  clk_out_a: assert property (rc_mode_in == $past(rc_mode_in) |-> osc_out_cycle_clock_out ==
    (rc_mode_in && (phase_three_out || phase_four_out))) else $error("clock out wrong");
endmodule : qps_props
bind qps_sequencer qps_props #(
  .PC_WIDTH    (PC_WIDTH),
  .INSTR_WIDTH (INSTR_WIDTH)
) chk_u (
  .clk_in                  (clk_in),
  .reset_in                (reset_in),
  .master_clear_n_in       (master_clear_n_in),
  .rc_mode_in              (rc_mode_in),
  .pc_load_in              (pc_load_in),
  .prog_word_in            (prog_word_in),
  .instr_out               (instr_out),
  .pc_target_in            (pc_target_in),
  .prog_addr_out           (prog_addr_out),
  .exec_valid_out          (exec_valid_out),
  .flush_out               (flush_out),
  .data_read_out           (data_read_out),
  .data_write_out          (data_write_out),
  .phase_one_out           (phase_one_out),
  .phase_two_out           (phase_two_out),
  .phase_three_out         (phase_three_out),
  .phase_four_out          (phase_four_out),
  .osc_out_cycle_clock_out (osc_out_cycle_clock_out)
);

// >>> tb/qps_partner.sv
// partner: program memory and master clear source
`timescale 1ns/1ns
module qps_partner
  import qps_pkg::*;
(
  input  wire logic [PC_W-1:0]    addr_in,
  input  wire logic               clear_req_in,
  output logic      [INSTR_W-1:0] word_out,
  output logic                    master_clear_n_out
);
  assign word_out           = {1'b1, addr_in};
  assign master_clear_n_out = ~clear_req_in;
endmodule : qps_partner

// >>> tb/quad_phase_instruction_sequencer_tb.sv
// testbench: quad phase instruction sequencer
`timescale 1ns/1ns
module quad_phase_instruction_sequencer_tb;
  import qps_pkg::*;
  logic clk_in = 1'b0, reset_in = 1'b1, rc_mode_in = 1'b0, pc_load_in = 1'b0, clr = 1'b0;
  logic [PC_W-1:0] pc_target_in = 13'h0000, prog_addr_out, a;
  logic [INSTR_W-1:0] prog_word_in, instr_out;
  logic master_clear_n_in, exec_valid_out, flush_out, p1, p2, p3, p4, rd, wr, ck;
  wire logic [3:0] ph = {p4, p3, p2, p1};
  int n_fail = 0, n_tests = 0;
  initial forever #5 clk_in = ~clk_in;
  qps_partner mem_u (.addr_in(prog_addr_out), .clear_req_in(clr), .word_out(prog_word_in),
    .master_clear_n_out(master_clear_n_in));
  qps_sequencer dut_u (.clk_in, .reset_in, .master_clear_n_in, .rc_mode_in, .prog_word_in,
    .pc_load_in, .pc_target_in, .prog_addr_out, .instr_out, .exec_valid_out, .flush_out,
    .phase_one_out(p1), .phase_two_out(p2), .phase_three_out(p3), .phase_four_out(p4),
    .data_read_out(rd), .data_write_out(wr), .osc_out_cycle_clock_out(ck));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // waits for phase k, sampled 1 ns after the edge
  task automatic to_phase(input int k);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_in);
      #1;
      if (ph[k] === 1'b1) return;
    end
    n_fail++;
    test_done();
  endtask : to_phase
  task automatic test_pipe;
    to_phase(1);
    a = prog_addr_out;
    repeat (3) begin
      to_phase(1);
      check(16'(ph), 16'h0002);
      check(16'(instr_out), {3'h1, a});
      check(16'(prog_addr_out), 16'(a + 13'h0001));
      check(16'({exec_valid_out, rd}), 16'h0003);
      a = prog_addr_out;
      to_phase(2);
      check(16'({rd, wr, ck}), 16'h0000);
      to_phase(3);
      check(16'(wr), 16'h0001);
    end
    $display("pipe done");
  endtask : test_pipe
  task automatic test_jump;
    to_phase(1);
    pc_target_in = 13'h1a5c;
    pc_load_in = 1'b1;
    to_phase(1);
    check(16'({flush_out, exec_valid_out, rd}), 16'h0004);
    check(16'(prog_addr_out), 16'h1a5d);
    to_phase(3);
    check(16'(wr), 16'h0000);
    to_phase(1);
    pc_load_in = 1'b0;
    check(16'({flush_out, exec_valid_out}), 16'h0001);
    check(16'(prog_addr_out), 16'h1a5e);
    check(16'(instr_out), 16'h3a5d);
    $display("jump done");
  endtask : test_jump
  task automatic test_late_jump;
    to_phase(3);
    pc_target_in = 13'h0123;
    pc_load_in = 1'b1;
    to_phase(0);
    pc_load_in = 1'b0;
    check(16'({flush_out, exec_valid_out}), 16'h0002);
    check(16'(prog_addr_out), 16'h0123);
    to_phase(0);
    check(16'({flush_out, exec_valid_out}), 16'h0001);
    check(16'(instr_out), 16'h2124);
    $display("late jump done");
  endtask : test_late_jump
  task automatic test_rc;
    rc_mode_in = 1'b1;
    to_phase(0);
    check(16'(ck), 16'h0000);
    to_phase(1);
    check(16'(ck), 16'h0000);
    to_phase(2);
    check(16'(ck), 16'h0001);
    to_phase(3);
    check(16'(ck), 16'h0001);
    rc_mode_in = 1'b0;
    to_phase(2);
    check(16'(ck), 16'h0000);
    $display("rc done");
  endtask : test_rc
  task automatic test_clear;
    clr = 1'b1;
    repeat (3) begin
      @(posedge clk_in);
      #1;
      check(16'(prog_addr_out), 16'h0000);
      check(16'(instr_out), 16'h0000);
      check(16'({exec_valid_out, flush_out, rd, wr, ck, ph}), 16'h0000);
    end
    clr = 1'b0;
    to_phase(1);
    to_phase(1);
    check(16'(exec_valid_out), 16'h0001);
    check(16'(prog_addr_out), 16'h0002);
    check(16'(instr_out), 16'h2001);
    $display("clear done");
  endtask : test_clear
  initial begin
    repeat (16) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    test_pipe();
    test_jump();
    test_late_jump();
    test_rc();
    test_clear();
    test_done();
  end
endmodule : quad_phase_instruction_sequencer_tb
